// ### core/psg_glue.sv
// Sync, trip and trigger glue around a bank of twelve modulators
`timescale 1ns/10ps
module psg_glue
   import psg_pkg::*;
#(
   // Stretch lengths in clock cycles
   parameter int SYNC_STRETCH = PSG_SYNC_STRETCH,
   parameter int SOC_STRETCH = PSG_SOC_STRETCH
)
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // External pins and control bits
   input wire logic [PSG_NUM_GPTRIP-1:0] gp_trip_lines_in,
   input wire logic timebase_clock_sync_bit_in,
   input wire logic ram_double_bit_error_in,
   input wire logic irq_expander_error_in,
   input wire logic encoder_error_in,
   input wire logic clock_failure_flag_in,
   input wire logic emulation_halt_in,
   // From the modulator bank
   input wire logic sync_out_first_instance_in,
   input wire psg_bank_evt_t bank_evt_in,
   // To the modulator bank
   output logic [PSG_NUM_INST-1:0] ext_sync_out,
   output logic [PSG_NUM_INST-1:0] timebase_sync_out,
   output logic [PSG_NUM_TRIP-1:0] trip_inputs_out,
   output logic [PSG_NUM_TZ-1:0] trip_zone_inputs_out,
   output logic [PSG_NUM_INST-1:0] high_res_modulator_out,
   // To pin multiplexer
   output logic sync_pin_out,
   output logic merged_conv_start_a_out,
   output logic merged_conv_start_b_out,
   // To converter subsystem and interrupt expander
   output psg_adc_trig_t adc_trig_out,
   output logic [PSG_NUM_INST-1:0] modulator_event_irq_out,
   output logic [PSG_NUM_INST-1:0] modulator_tripzone_irq_out
);
   // Counter width must hold the longer stretch
   localparam logic [PSG_CNT_W-1:0] SYNC_LOAD = PSG_CNT_W'(SYNC_STRETCH);
   localparam logic [PSG_CNT_W-1:0] SOC_LOAD = PSG_CNT_W'(SOC_STRETCH);
   localparam int MISC_W = 4;

   // Next count of a retriggerable stretcher
   function automatic logic [PSG_CNT_W-1:0] stretch_next(input logic trig,
      input logic [PSG_CNT_W-1:0] cnt, input logic [PSG_CNT_W-1:0] load);
      if (trig) begin
         stretch_next = load;
      end else if (cnt != PSG_CNT_ZERO) begin
         stretch_next = cnt - PSG_CNT_ONE;
      end else begin
         stretch_next = PSG_CNT_ZERO;
      end
   endfunction

   // Pin-side inputs pass three flops; a change counts when stages 2 and 3 agree
   logic [PSG_NUM_GPTRIP-1:0] gp_s1_q, gp_s2_q, gp_s3_q, gp_q;
   logic [MISC_W-1:0] misc_s1_q, misc_s2_q, misc_s3_q, misc_q;
   logic [MISC_W-1:0] misc_raw;
   assign misc_raw = {clock_failure_flag_in, encoder_error_in, irq_expander_error_in,
                      ram_double_bit_error_in};
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         gp_s1_q <= '0;
         gp_s2_q <= '0;
         gp_s3_q <= '0;
         gp_q <= '0;
         misc_s1_q <= '0;
         misc_s2_q <= '0;
         misc_s3_q <= '0;
         misc_q <= '0;
      end else begin
         gp_s1_q <= gp_trip_lines_in;
         gp_s2_q <= gp_s1_q;
         gp_s3_q <= gp_s2_q;
         for (int i = 0; i < PSG_NUM_GPTRIP; i++) begin
            if (gp_s2_q[i] == gp_s3_q[i]) begin
               gp_q[i] <= gp_s3_q[i];
            end
         end
         misc_s1_q <= misc_raw;
         misc_s2_q <= misc_s1_q;
         misc_s3_q <= misc_s2_q;
         for (int i = 0; i < MISC_W; i++) begin
            if (misc_s2_q[i] == misc_s3_q[i]) begin
               misc_q[i] <= misc_s3_q[i];
            end
         end
      end
   end

   // Fan-out to the modulator bank; registered so outputs come from flops
   // Only 1 filter stage apart, so a 2-cycle external pulse still passes
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ext_sync_out <= '0;
         timebase_sync_out <= '0;
         trip_inputs_out <= '0;
         trip_zone_inputs_out <= '0;
         high_res_modulator_out <= '0;
      end else begin
         ext_sync_out <= {PSG_NUM_INST{gp_q[0]}};
         timebase_sync_out <= {PSG_NUM_INST{timebase_clock_sync_bit_in}};
         // Fourteen sources for fifteen inputs; the top input has none and stays low
         trip_inputs_out <= {1'b0, misc_q[1], misc_q[0], gp_q};
         trip_zone_inputs_out <= {emulation_halt_in, misc_q[3], misc_q[2],
                                  gp_q[PSG_NUM_TZ_GP-1:0]};
         for (int i = 0; i < PSG_NUM_INST; i++) begin
            high_res_modulator_out[i] <= (i < PSG_NUM_HR);
         end
      end
   end

   // Stretchers; retrigger restarts the full width rather than adding to it
   logic [PSG_CNT_W-1:0] sync_cnt_q, conv_start_a_cnt_q, conv_start_b_cnt_q;
   logic [PSG_CNT_W-1:0] sync_cnt_d, conv_start_a_cnt_d, conv_start_b_cnt_d;
   assign sync_cnt_d = stretch_next(sync_out_first_instance_in, sync_cnt_q, SYNC_LOAD);
   assign conv_start_a_cnt_d = stretch_next(|bank_evt_in.conv_start_a, conv_start_a_cnt_q, SOC_LOAD);
   assign conv_start_b_cnt_d = stretch_next(|bank_evt_in.conv_start_b, conv_start_b_cnt_q, SOC_LOAD);
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_cnt_q <= PSG_CNT_ZERO;
         conv_start_a_cnt_q <= PSG_CNT_ZERO;
         conv_start_b_cnt_q <= PSG_CNT_ZERO;
         sync_pin_out <= 1'b0;
         merged_conv_start_a_out <= 1'b0;
         merged_conv_start_b_out <= 1'b0;
      end else begin
         sync_cnt_q <= sync_cnt_d;
         conv_start_a_cnt_q <= conv_start_a_cnt_d;
         conv_start_b_cnt_q <= conv_start_b_cnt_d;
         sync_pin_out <= (sync_cnt_d != PSG_CNT_ZERO);
         merged_conv_start_a_out <= (conv_start_a_cnt_d != PSG_CNT_ZERO);
         merged_conv_start_b_out <= (conv_start_b_cnt_d != PSG_CNT_ZERO);
      end
   end

   // Converter triggers and interrupt lines, one flop of latency
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         adc_trig_out <= '0;
         modulator_event_irq_out <= '0;
         modulator_tripzone_irq_out <= '0;
      end else begin
         adc_trig_out.conv_start_a <= bank_evt_in.conv_start_a[PSG_NUM_ADC-1:0];
         adc_trig_out.conv_start_b <= bank_evt_in.conv_start_b[PSG_NUM_ADC-1:0];
         modulator_event_irq_out <= bank_evt_in.event_irq;
         modulator_tripzone_irq_out <= bank_evt_in.tripzone_irq;
      end
   end

   // Helper: cycles the merged A trigger has stood since its last strobe
   // A 32-cycle run is too long for a repetition, so it is counted here
   logic [PSG_CNT_W-1:0] conv_start_a_age_q;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         conv_start_a_age_q <= PSG_CNT_ZERO;
      end else if (|bank_evt_in.conv_start_a) begin
         conv_start_a_age_q <= PSG_CNT_ZERO;
      end else if (merged_conv_start_a_out && conv_start_a_age_q != SOC_LOAD) begin
         conv_start_a_age_q <= conv_start_a_age_q + PSG_CNT_ONE; // Saturates so a stuck output cannot wrap
      end
   end

   // Checks; repetition counts assume the default stretch lengths
   sequence s_sync_hit;
      sync_out_first_instance_in;
   endsequence
   sequence s_sync_held;
      sync_pin_out [*8];
   endsequence
   sequence s_sync_quiet;
      $fell(sync_out_first_instance_in) ##0 !sync_out_first_instance_in [*8];
   endsequence
   property p_sync_stretch;
      @(posedge core_clk_in) disable iff (rst_in)
         s_sync_hit |=> s_sync_held;
   endproperty
   a_sync_stretch_width: assert property (p_sync_stretch)
      else $error("sync output shorter than 8 cycles");
   a_sync_release: assert property (@(posedge core_clk_in) disable iff (rst_in)
      s_sync_quiet |=> !sync_pin_out)
      else $error("sync output longer than 8 cycles");
   a_conv_start_a_width: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (|bank_evt_in.conv_start_a) |=> merged_conv_start_a_out [*8])
      else $error("merged A trigger dropped early");
   a_conv_start_a_longest: assert property (@(posedge core_clk_in) disable iff (rst_in)
      merged_conv_start_a_out |-> conv_start_a_age_q < SOC_LOAD)
      else $error("merged A trigger stood past its stretch");
   a_conv_start_a_end: assert property (@(posedge core_clk_in) disable iff (rst_in)
      conv_start_a_cnt_q == PSG_CNT_ONE && !(|bank_evt_in.conv_start_a) |=> !merged_conv_start_a_out)
      else $error("merged A trigger did not end");
   a_conv_start_b_reload: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (|bank_evt_in.conv_start_b) |=> conv_start_b_cnt_q == SOC_LOAD && merged_conv_start_b_out)
      else $error("merged B stretcher not reloaded");
   a_conv_start_b_end: assert property (@(posedge core_clk_in) disable iff (rst_in)
      conv_start_b_cnt_q == PSG_CNT_ONE && !(|bank_evt_in.conv_start_b) |=> !merged_conv_start_b_out)
      else $error("merged B trigger did not end");
   a_adc_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> adc_trig_out.conv_start_a == $past(bank_evt_in.conv_start_a[PSG_NUM_ADC-1:0]))
      else $error("converter trigger mismatch");
   a_adc_route_b: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> adc_trig_out.conv_start_b == $past(bank_evt_in.conv_start_b[PSG_NUM_ADC-1:0]))
      else $error("converter B trigger mismatch");
   a_irq_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> modulator_tripzone_irq_out == $past(bank_evt_in.tripzone_irq))
      else $error("trip-zone interrupt mismatch");
   a_event_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> modulator_event_irq_out == $past(bank_evt_in.event_irq))
      else $error("event interrupt mismatch");
   a_trip_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> trip_inputs_out[PSG_NUM_GPTRIP-1:0] == $past(gp_q)
               && trip_zone_inputs_out[PSG_NUM_TZ-1] == $past(emulation_halt_in))
      else $error("trip routing mismatch");
   a_trip_errors: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> trip_inputs_out[PSG_NUM_TRIP-1:PSG_NUM_GPTRIP] == {1'b0, $past(misc_q[1:0])})
      else $error("trip error sources mismatch");
   a_tz_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> trip_zone_inputs_out[PSG_NUM_TZ-2:0]
               == $past({misc_q[3:2], gp_q[PSG_NUM_TZ_GP-1:0]}))
      else $error("trip-zone sources mismatch");
   a_sync_fanout: assert property (@(posedge core_clk_in) disable iff (rst_in)
      1'b1 |=> ext_sync_out == {PSG_NUM_INST{$past(gp_q[0])}}
               && timebase_sync_out == {PSG_NUM_INST{$past(timebase_clock_sync_bit_in)}})
      else $error("sync fan-out mismatch");
   a_hr_flags: assert property (@(posedge core_clk_in) disable iff (rst_in)
      $past(!rst_in) |-> high_res_modulator_out == 12'h0ff)
      else $error("high-resolution flags wrong");
endmodule

// ### core/psg_pkg.sv
// Constants and carrier types for the modulator bank glue block
package psg_pkg;
   localparam int PSG_NUM_INST = 12;
   localparam int PSG_NUM_HR = 8;
   localparam int PSG_NUM_ADC = 9;
   localparam int PSG_NUM_GPTRIP = 12;
   localparam int PSG_NUM_TRIP = 15;
   localparam int PSG_NUM_TZ = 6;
   localparam int PSG_NUM_TZ_GP = 3;
   localparam int PSG_SYNC_STRETCH = 8;
   localparam int PSG_SOC_STRETCH = 32;
   localparam int PSG_CNT_W = 6;
   localparam logic [PSG_CNT_W-1:0] PSG_CNT_ZERO = 6'h00;
   localparam logic [PSG_CNT_W-1:0] PSG_CNT_ONE = 6'h01;

   // Per-instance strobes coming from the modulator bank
   typedef struct packed {
      logic [PSG_NUM_INST-1:0] conv_start_a;
      logic [PSG_NUM_INST-1:0] conv_start_b;
      logic [PSG_NUM_INST-1:0] event_irq;
      logic [PSG_NUM_INST-1:0] tripzone_irq;
   } psg_bank_evt_t;

   // Unmerged converter triggers, instances 1..9
   typedef struct packed {
      logic [PSG_NUM_ADC-1:0] conv_start_a;
      logic [PSG_NUM_ADC-1:0] conv_start_b;
   } psg_adc_trig_t;
endpackage

// ### tb/psg_bank_model.sv
// Behavioural stand-in for the modulator bank feeding the glue block
`timescale 1ns/10ps
module psg_bank_model
   import psg_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Requests from the bench
   input wire logic sync_req_in,
   input wire psg_bank_evt_t evt_req_in,
   // Toward the glue block
   output logic sync_out,
   output psg_bank_evt_t evt_out
);
   // Strobes leave on a clock edge, as a real bank would launch them
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_out <= 1'b0;
         evt_out <= '0;
      end else begin
         sync_out <= sync_req_in;
         evt_out <= evt_req_in;
      end
   end
endmodule

// ### tb/psg_glue_tb.sv
// Self-checking bench for the modulator bank glue block
`timescale 1ns/10ps
module psg_glue_tb;
   import psg_pkg::*;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [PSG_NUM_GPTRIP-1:0] gp = '0;
   logic tb_bit = 1'b0, ram_err = 1'b0, irq_err = 1'b0, enc_err = 1'b0;
   logic clk_fail = 1'b0, halt = 1'b0, sync_req = 1'b0, sync_m, sync_pin, soc_a, soc_b;
   psg_bank_evt_t evt_req = '0, evt_m;
   logic [PSG_NUM_INST-1:0] ext_sync, tb_sync, hr, ev_irq, tz_irq;
   logic [PSG_NUM_TRIP-1:0] trip;
   logic [PSG_NUM_TZ-1:0] tz;
   psg_adc_trig_t adc;
   int err_count = 0, checked = 0, n;
   psg_bank_evt_t row_in [3];
   logic [17:0] row_adc [3];

   // Half-period toggle gives 200 MHz
   always #2.5 core_clk_in = ~core_clk_in;

   psg_bank_model psg_bank_model_i (.clk_in(core_clk_in), .rst_in(rst_in),
      .sync_req_in(sync_req), .evt_req_in(evt_req), .sync_out(sync_m), .evt_out(evt_m));
   psg_glue psg_glue_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .gp_trip_lines_in(gp),
      .timebase_clock_sync_bit_in(tb_bit), .ram_double_bit_error_in(ram_err),
      .irq_expander_error_in(irq_err), .encoder_error_in(enc_err),
      .clock_failure_flag_in(clk_fail), .emulation_halt_in(halt),
      .sync_out_first_instance_in(sync_m), .bank_evt_in(evt_m), .ext_sync_out(ext_sync),
      .timebase_sync_out(tb_sync), .trip_inputs_out(trip), .trip_zone_inputs_out(tz),
      .high_res_modulator_out(hr), .sync_pin_out(sync_pin), .merged_conv_start_a_out(soc_a),
      .merged_conv_start_b_out(soc_b), .adc_trig_out(adc), .modulator_event_irq_out(ev_irq),
      .modulator_tripzone_irq_out(tz_irq));

   // Inputs always move 1 ns after the edge, away from sampling
   task step(input int k);
      repeat (k) @(posedge core_clk_in);
      #1;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask

   // Bounded window; a stretcher stuck high shows up as a wrong count
   task pulse_run(input int sel, input logic [63:0] pat, output int cnt);
      cnt = 0;
      for (int i = 0; i < 64; i++) begin
         sync_req = (sel == 0) & pat[i];
         evt_req.conv_start_a = {pat[i] & (sel == 1), 11'h000};
         evt_req.conv_start_b = {11'h000, pat[i] & (sel == 2)};
         step(1);
         if ((sel == 0 ? sync_pin : sel == 1 ? soc_a : soc_b) === 1'b1) cnt++;
      end
   endtask

   task summarize;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Hang guard
   initial begin
      #100000;
      err_count++;
      summarize();
   end

   initial begin
      row_in[0] = {12'h001, 12'h800, 12'h555, 12'haaa};
      row_adc[0] = {9'h001, 9'h000};
      row_in[1] = {12'h100, 12'h1ff, 12'h000, 12'hfff};
      row_adc[1] = {9'h100, 9'h1ff};
      row_in[2] = {12'he00, 12'h600, 12'hfff, 12'h001};
      row_adc[2] = {9'h000, 9'h000};
      step(4);
      rst_in = 1'b0;
      step(1);
      chk("high_res", 12'h0ff, hr);
      // Ordinary routing rows: model edge plus design register
      for (int i = 0; i < 3; i++) begin
         evt_req = row_in[i];
         step(2);
         chk("adc_trig", row_adc[i], adc);
         chk("event_irq", row_in[i].event_irq, ev_irq);
         chk("tripzone_irq", row_in[i].tripzone_irq, tz_irq);
      end
      evt_req = '0;
      step(40);
      $display("routing test done");
      // Pins held far longer than the minimum pulse
      gp = 12'h007;
      {tb_bit, ram_err, irq_err, enc_err, clk_fail, halt} = 6'h3f;
      // Three sync flops, the agreement filter and the output register: 5 edges
      step(5);
      chk("ext_sync", 12'hfff, ext_sync);
      chk("timebase_sync", 12'hfff, tb_sync);
      chk("trip_lines", 12'h007, trip[11:0]);
      chk("trip_errors", 2, $countones(trip[14:12]));
      chk("trip_zone", 6'h3f, tz);
      gp = '0;
      {tb_bit, ram_err, irq_err, enc_err, clk_fail, halt} = 6'h00;
      step(5);
      chk("trip_clear", 0, {trip, tz});
      chk("timebase_clear", 0, tb_sync);
      // Shortest legal external sync pulse must still reach the bank
      gp = 12'h001;
      step(2);
      gp = '0;
      step(3);
      chk("ext_sync_short", 12'hfff, ext_sync);
      step(4);
      chk("ext_sync_idle", 0, ext_sync);
      $display("pin test done");
      // Single, retriggered and held strobes
      pulse_run(0, 64'h1, n);
      chk("sync_len", 8, n);
      pulse_run(0, 64'h21, n);
      chk("sync_retrig", 13, n);
      pulse_run(1, 64'h1, n);
      chk("merged_a_len", 32, n);
      pulse_run(1, 64'h7, n);
      chk("merged_a_held", 34, n);
      pulse_run(2, 64'h1, n);
      chk("merged_b_len", 32, n);
      $display("stretch test done");
      // Reset in the middle of a stretch
      sync_req = 1'b1;
      evt_req.conv_start_a = 12'h001;
      step(3);
      rst_in = 1'b1;
      sync_req = 1'b0;
      evt_req = '0;
      step(1);
      chk("reset_outputs", 0, {sync_pin, soc_a, hr});
      rst_in = 1'b0;
      step(1);
      chk("high_res_again", 12'h0ff, hr);
      $display("reset test done");
      summarize();
   end
endmodule
